// [rtl/sfp_pkg.sv]
package sfp_pkg;

  // serial command that opens the parameter space
  localparam logic [7:0]  SFP_OP_READ_PARAM   = 8'h5a;
  localparam logic [2:0]  SFP_BIT_LAST        = 3'h7;
  localparam logic [1:0]  SFP_ADDR_BYTE_LAST  = 2'h2;
  localparam logic [23:0] SFP_ADDR_STEP       = 24'h000001;

  // synchroniser lanes and their idle levels
  localparam int          SFP_PIN_COUNT       = 3;
  localparam int          SFP_PIN_CLK         = 0;
  localparam int          SFP_PIN_CS_N        = 1;
  localparam int          SFP_PIN_DIN         = 2;
  localparam logic [2:0]  SFP_PIN_IDLE        = 3'h2;

  // header locations and contents
  localparam logic [23:0] SFP_HDR_SIG0_ADDR   = 24'h000000;
  localparam logic [23:0] SFP_HDR_SIG1_ADDR   = 24'h000001;
  localparam logic [23:0] SFP_HDR_SIG2_ADDR   = 24'h000002;
  localparam logic [23:0] SFP_HDR_SIG3_ADDR   = 24'h000003;
  localparam logic [23:0] SFP_HDR_MINOR_ADDR  = 24'h000004;
  localparam logic [23:0] SFP_HDR_MAJOR_ADDR  = 24'h000005;
  localparam logic [23:0] SFP_HDR_NPH_ADDR    = 24'h000006;
  localparam logic [23:0] SFP_HDR_ID_ADDR     = 24'h000008;
  localparam logic [23:0] SFP_HDR_TMIN_ADDR   = 24'h000009;
  localparam logic [23:0] SFP_HDR_TMAJ_ADDR   = 24'h00000a;
  localparam logic [23:0] SFP_HDR_TLEN_ADDR   = 24'h00000b;
  localparam logic [23:0] SFP_HDR_TPTR_ADDR   = 24'h00000c;
  localparam logic [23:0] SFP_HDR_TPTR1_ADDR  = 24'h00000d;
  localparam logic [23:0] SFP_HDR_TPTR2_ADDR  = 24'h00000e;
  localparam logic [7:0]  SFP_HDR_SIG0        = 8'h53;
  localparam logic [7:0]  SFP_HDR_SIG1        = 8'h46;
  localparam logic [7:0]  SFP_HDR_SIG2        = 8'h44;
  localparam logic [7:0]  SFP_HDR_SIG3        = 8'h50;
  localparam logic [7:0]  SFP_HDR_MINOR       = 8'h08;
  localparam logic [7:0]  SFP_HDR_MAJOR       = 8'h01;
  localparam logic [7:0]  SFP_HDR_NPH         = 8'h00;
  localparam logic [7:0]  SFP_HDR_ID          = 8'h00;
  localparam logic [7:0]  SFP_HDR_TMIN        = 8'h07;
  localparam logic [7:0]  SFP_HDR_TMAJ        = 8'h01;
  localparam logic [7:0]  SFP_HDR_TLEN        = 8'h10;
  localparam logic [7:0]  SFP_HDR_TPTR        = 8'h30;
  localparam logic [7:0]  SFP_HDR_TPTR_HI     = 8'h00;

  // basic parameter table, absolute byte addresses
  localparam logic [23:0] SFP_ERASE_BUF_CAPS_ADDR   = 24'h000030;
  localparam logic [23:0] SFP_SMALL_ERASE_OP_ADDR   = 24'h000031;
  localparam logic [23:0] SFP_READ_MODE_FLAGS_ADDR  = 24'h000032;
  localparam logic [23:0] SFP_WORD1_UNUSED_ADDR     = 24'h000033;
  localparam logic [23:0] SFP_DENSITY0_ADDR         = 24'h000034;
  localparam logic [23:0] SFP_DENSITY1_ADDR         = 24'h000035;
  localparam logic [23:0] SFP_DENSITY2_ADDR         = 24'h000036;
  localparam logic [23:0] SFP_DENSITY3_ADDR         = 24'h000037;
  localparam logic [23:0] SFP_QIO_CYC_ADDR          = 24'h000038;
  localparam logic [23:0] SFP_QIO_OP_ADDR           = 24'h000039;
  localparam logic [23:0] SFP_QOUT_CYC_ADDR         = 24'h00003a;
  localparam logic [23:0] SFP_QOUT_OP_ADDR          = 24'h00003b;
  localparam logic [23:0] SFP_DOUT_CYC_ADDR         = 24'h00003c;
  localparam logic [23:0] SFP_DOUT_OP_ADDR          = 24'h00003d;
  localparam logic [23:0] SFP_DIO_CYC_ADDR          = 24'h00003e;
  localparam logic [23:0] SFP_DIO_OP_ADDR           = 24'h00003f;
  localparam logic [23:0] SFP_WIDE_CMD_FLAGS_ADDR   = 24'h000040;
  localparam logic [23:0] SFP_WORD5_RSVD_ADDR       = 24'h000041;

  localparam logic [7:0]  SFP_ERASE_BUF_CAPS   = 8'he5;
  localparam logic [7:0]  SFP_SMALL_ERASE_OP   = 8'h20;
  localparam logic [7:0]  SFP_READ_MODE_FLAGS  = 8'hf1;
  localparam logic [7:0]  SFP_DENSITY0         = 8'hff;
  localparam logic [7:0]  SFP_DENSITY1         = 8'hff;
  localparam logic [7:0]  SFP_DENSITY2         = 8'h3f;
  localparam logic [7:0]  SFP_DENSITY3         = 8'h00;
  localparam logic [7:0]  SFP_QIO_CYC          = 8'h44;
  localparam logic [7:0]  SFP_QIO_OP           = 8'heb;
  localparam logic [7:0]  SFP_QOUT_CYC         = 8'h08;
  localparam logic [7:0]  SFP_QOUT_OP          = 8'h6b;
  localparam logic [7:0]  SFP_DOUT_CYC         = 8'h08;
  localparam logic [7:0]  SFP_DOUT_OP          = 8'h3b;
  localparam logic [7:0]  SFP_DIO_CYC          = 8'h80;
  localparam logic [7:0]  SFP_DIO_OP           = 8'hbb;
  localparam logic [7:0]  SFP_WIDE_CMD_FLAGS   = 8'hee;
  localparam logic [7:0]  SFP_UNUSED_BYTE      = 8'hff;

  typedef enum {
    SFP_ST_IDLE,
    SFP_ST_CMD,
    SFP_ST_ADDR,
    SFP_ST_DUMMY,
    SFP_ST_DATA,
    SFP_ST_IGNORE
  } sfp_state_t;

endpackage

// [rtl/sfp_pin_sync.sv]
module sfp_pin_sync
  import sfp_pkg::*;
#(
  parameter int                 W    = SFP_PIN_COUNT,
  parameter logic [W-1:0]       IDLE = SFP_PIN_IDLE
)
(
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [W-1:0]     pin_in,
  output logic      [W-1:0]     level,
  output logic      [W-1:0]     rise,
  output logic      [W-1:0]     fall
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          s1_r[i]  <= IDLE[i];
          s2_r[i]  <= IDLE[i];
          s3_r[i]  <= IDLE[i];
          level[i] <= IDLE[i];
          rise[i]  <= 1'b0;
          fall[i]  <= 1'b0;
        end
        else
        begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // a change counts only once the last two stages agree
          rise[i] <= (s2_r[i] == s3_r[i]) && s3_r[i] && !level[i];
          fall[i] <= (s2_r[i] == s3_r[i]) && !s3_r[i] && level[i];
          if (s2_r[i] == s3_r[i])
            level[i] <= s3_r[i];
        end
      end
    end
  endgenerate

endmodule

// [rtl/sfp_param_rom.sv]
module sfp_param_rom
  import sfp_pkg::*;
#(
  // arbitrary neutral value
  parameter logic [7:0]         VENDOR_ID = 8'h00
)
(
  input  wire logic [23:0]      addr,
  output logic      [7:0]       data
);

  function automatic logic [7:0] table_byte(input logic [23:0] a);
    logic [7:0] b;
    b = SFP_UNUSED_BYTE;
    case (a)
      SFP_HDR_SIG0_ADDR:        b = SFP_HDR_SIG0;
      SFP_HDR_SIG1_ADDR:        b = SFP_HDR_SIG1;
      SFP_HDR_SIG2_ADDR:        b = SFP_HDR_SIG2;
      SFP_HDR_SIG3_ADDR:        b = SFP_HDR_SIG3;
      SFP_HDR_MINOR_ADDR:       b = SFP_HDR_MINOR;
      SFP_HDR_MAJOR_ADDR:       b = SFP_HDR_MAJOR;
      SFP_HDR_NPH_ADDR:         b = SFP_HDR_NPH;
      SFP_HDR_ID_ADDR:          b = VENDOR_ID ^ SFP_HDR_ID;
      SFP_HDR_TMIN_ADDR:        b = SFP_HDR_TMIN;
      SFP_HDR_TMAJ_ADDR:        b = SFP_HDR_TMAJ;
      SFP_HDR_TLEN_ADDR:        b = SFP_HDR_TLEN;
      SFP_HDR_TPTR_ADDR:        b = SFP_HDR_TPTR;
      SFP_HDR_TPTR1_ADDR:       b = SFP_HDR_TPTR_HI;
      SFP_HDR_TPTR2_ADDR:       b = SFP_HDR_TPTR_HI;
      SFP_ERASE_BUF_CAPS_ADDR:  b = SFP_ERASE_BUF_CAPS;
      SFP_SMALL_ERASE_OP_ADDR:  b = SFP_SMALL_ERASE_OP;
      SFP_READ_MODE_FLAGS_ADDR: b = SFP_READ_MODE_FLAGS;
      SFP_DENSITY0_ADDR:        b = SFP_DENSITY0;
      SFP_DENSITY1_ADDR:        b = SFP_DENSITY1;
      SFP_DENSITY2_ADDR:        b = SFP_DENSITY2;
      SFP_DENSITY3_ADDR:        b = SFP_DENSITY3;
      SFP_QIO_CYC_ADDR:         b = SFP_QIO_CYC;
      SFP_QIO_OP_ADDR:          b = SFP_QIO_OP;
      SFP_QOUT_CYC_ADDR:        b = SFP_QOUT_CYC;
      SFP_QOUT_OP_ADDR:         b = SFP_QOUT_OP;
      SFP_DOUT_CYC_ADDR:        b = SFP_DOUT_CYC;
      SFP_DOUT_OP_ADDR:         b = SFP_DOUT_OP;
      SFP_DIO_CYC_ADDR:         b = SFP_DIO_CYC;
      SFP_DIO_OP_ADDR:          b = SFP_DIO_OP;
      SFP_WIDE_CMD_FLAGS_ADDR:  b = SFP_WIDE_CMD_FLAGS;
      default:                  b = SFP_UNUSED_BYTE;
    endcase
    return b;
  endfunction

  // contents are fixed, no write path exists
  assign data = table_byte(addr);

endmodule

// [rtl/sfp_top.sv]
module sfp_top
  import sfp_pkg::*;
#(
  // arbitrary neutral value
  parameter logic [7:0]         VENDOR_ID = 8'h00
)
(
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             spi_clk,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_io0,
  output logic                  spi_io1_o,
  output logic                  spi_io1_oe,
  output logic                  param_read_active
);

  logic [SFP_PIN_COUNT-1:0] pin_lvl;
  logic [SFP_PIN_COUNT-1:0] pin_rise;

  sfp_state_t   state_r;
  logic [2:0]   bit_cnt_r;
  logic [1:0]   byte_cnt_r;
  logic [7:0]   shift_in_r;
  logic [23:0]  addr_r;
  logic [7:0]   shift_out_r;
  logic [23:0]  rom_addr;
  logic [7:0]   rom_data;
  logic [7:0]   rx_byte;
  logic         clk_rise;
  logic         deselected;
  logic         din;
  logic         byte_end;

  // clock, select and data share one pipeline, so data stays aligned to edges
  sfp_pin_sync #(
    .W    (SFP_PIN_COUNT),
    .IDLE (SFP_PIN_IDLE)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin_in  ({spi_io0, spi_cs_n, spi_clk}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    ()
  );

  sfp_param_rom #(
    .VENDOR_ID (VENDOR_ID)
  ) u_rom (
    .addr (rom_addr),
    .data (rom_data)
  );

  assign clk_rise   = pin_rise[SFP_PIN_CLK];
  assign deselected = pin_lvl[SFP_PIN_CS_N];
  assign din        = pin_lvl[SFP_PIN_DIN];
  assign rx_byte    = {shift_in_r[6:0], din};
  assign byte_end   = clk_rise && (bit_cnt_r == SFP_BIT_LAST);
  // next byte is fetched while the address steps
  assign rom_addr   = (state_r == SFP_ST_DATA) ? addr_r + SFP_ADDR_STEP : addr_r;

  always_ff @(posedge clock)
  begin
    if (sys_rst || deselected)
      state_r <= SFP_ST_IDLE;
    else
    begin
      case (state_r)
        SFP_ST_IDLE:
          state_r <= SFP_ST_CMD;
        SFP_ST_CMD:
          if (byte_end)
            state_r <= (rx_byte == SFP_OP_READ_PARAM) ? SFP_ST_ADDR : SFP_ST_IGNORE;
        SFP_ST_ADDR:
          if (byte_end && byte_cnt_r == SFP_ADDR_BYTE_LAST)
            state_r <= SFP_ST_DUMMY;
        SFP_ST_DUMMY:
          if (byte_end)
            state_r <= SFP_ST_DATA;
        SFP_ST_DATA:
          state_r <= SFP_ST_DATA;
        SFP_ST_IGNORE:
          state_r <= SFP_ST_IGNORE;
        default:
          state_r <= SFP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || state_r == SFP_ST_IDLE)
    begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 2'h0;
      shift_in_r <= 8'h00;
    end
    else if (clk_rise)
    begin
      bit_cnt_r  <= bit_cnt_r + 3'h1;
      shift_in_r <= rx_byte;
      if (state_r == SFP_ST_ADDR && bit_cnt_r == SFP_BIT_LAST)
        byte_cnt_r <= byte_cnt_r + 2'h1;
    end
  end

  // address shifts in msb first; an unmatched command leaves it untouched
  always_ff @(posedge clock)
  begin
    if (sys_rst || state_r == SFP_ST_IDLE)
      addr_r <= 24'h000000;
    else if (clk_rise && state_r == SFP_ST_ADDR)
      addr_r <= {addr_r[22:0], din};
    else if (byte_end && state_r == SFP_ST_DATA)
      addr_r <= addr_r + SFP_ADDR_STEP;
  end

  // output changes about five clocks after the host's sampling edge, leaving a little under half a
  // period of margin; a host using mode 0 sees data slightly after its falling edge
  always_ff @(posedge clock)
  begin
    if (sys_rst || state_r == SFP_ST_IDLE || state_r == SFP_ST_IGNORE)
    begin
      shift_out_r <= 8'h00;
      spi_io1_o   <= 1'b0;
      spi_io1_oe  <= 1'b0;
    end
    else if (byte_end && (state_r == SFP_ST_DUMMY || state_r == SFP_ST_DATA))
    begin
      shift_out_r <= rom_data;
      spi_io1_o   <= rom_data[7];
      spi_io1_oe  <= 1'b1;
    end
    else if (clk_rise && state_r == SFP_ST_DATA)
    begin
      shift_out_r <= {shift_out_r[6:0], 1'b0};
      spi_io1_o   <= shift_out_r[6];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      param_read_active <= 1'b0;
    else
      param_read_active <= (state_r == SFP_ST_ADDR) || (state_r == SFP_ST_DUMMY) || (state_r == SFP_ST_DATA);
  end

endmodule

// [verif/sfp_top_asserts.sv]
module sfp_top_chk
  import sfp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_io0,
  input wire logic spi_io1_o,
  input wire logic spi_io1_oe,
  input wire logic param_read_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_d_r;
  logic [5:0] rise_cnt_r;
  logic [3:0] since_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge clock)
  begin
    clk_d_r <= spi_clk;
  end

  // saturates: only the first 40 edges of a frame matter here
  always_ff @(posedge clock)
  begin
    if (sys_rst || spi_cs_n)
      rise_cnt_r <= 6'h00;
    else if (spi_clk && !clk_d_r && rise_cnt_r != 6'h3f)
      rise_cnt_r <= rise_cnt_r + 6'h01;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || (spi_clk && !clk_d_r))
      since_r <= 4'h0;
    else if (since_r != 4'hf)
      since_r <= since_r + 4'h1;
  end

  sequence s_cs_up;
    $rose(spi_cs_n);
  endsequence

  sequence s_idle;
    spi_cs_n [*8];
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0) $fell(sys_rst) |-> !spi_io1_oe && !param_read_active && !spi_io1_o)
    else $error("outputs not quiet after reset");
  a_idle_quiet: assert property (s_idle |-> !spi_io1_oe && !param_read_active)
    else $error("outputs active while deselected");
  a_oe_drop: assert property (s_cs_up |-> ##[1:8] !spi_io1_oe)
    else $error("output enable held after deselect");
  a_active_drop: assert property (s_cs_up |-> ##[1:8] !param_read_active)
    else $error("read active held after deselect");
  a_active_start: assert property ($rose(param_read_active) |-> rise_cnt_r == 6'h08)
    else $error("read active not after eighth clock");
  a_oe_start: assert property ($rose(spi_io1_oe) |-> rise_cnt_r == 6'h28 && !spi_cs_n)
    else $error("data not after fortieth clock");
  a_oe_in_read: assert property (spi_io1_oe && !spi_cs_n |-> param_read_active)
    else $error("driving outside a parameter read");
  a_out_steady: assert property (spi_io1_oe && $past(spi_io1_oe) && !spi_cs_n && $changed(spi_io1_o)
    |-> since_r inside {[4'h1:4'h6]})
    else $error("data bit changed away from serial clock edge");
endmodule

bind sfp_top sfp_top_chk chk_u (.clock(clock), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
  .spi_io0(spi_io0), .spi_io1_o(spi_io1_o), .spi_io1_oe(spi_io1_oe), .param_read_active(param_read_active));

// [verif/sfp_host_model.sv]
module sfp_host_model
(
  input  wire logic clock,
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_io0,
  input  wire logic spi_io1_o,
  input  wire logic spi_io1_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_q [$];
  logic       alt_r = 1'b0;
  wire  logic miso;

  // released line shows a toggling pattern, never a held value
  assign miso = spi_io1_oe ? spi_io1_o : alt_r;
  always @(posedge clock) alt_r <= ~alt_r;

  initial
  begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_io0 = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input int n);
    logic [39:0] hdr;
    logic [7:0]  b;
    hdr = {op, addr, 8'h00};
    b = 8'h00;
    rd_q = {};
    half();
    spi_cs_n = 1'b0;
    for (int i = 39; i >= 0; i--)
    begin
      spi_io0 = (i < 8) ? ~spi_io0 : hdr[i];
      half();
      spi_clk = 1'b1;
      half();
      spi_clk = 1'b0;
    end
    for (int k = 0; k < n; k++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        half();
        spi_clk = 1'b1;
        b = {b[6:0], miso};
        half();
        spi_clk = 1'b0;
      end
      rd_q.push_back(b);
    end
    half();
    spi_cs_n = 1'b1;
    half();
    half();
  endtask
endmodule

// [verif/tb.sv]
module tb
  import sfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic sys_rst;
  wire  logic spi_clk;
  wire  logic spi_cs_n;
  wire  logic spi_io0;
  logic spi_io1_o;
  logic spi_io1_oe;
  logic param_read_active;
  logic oe_seen;
  logic act_seen;
  int   n_fail = 0;
  int   tests_run = 0;
  int   cyc = 0;

  sfp_top dut_u (.clock(clock), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_io0(spi_io0),
    .spi_io1_o(spi_io1_o), .spi_io1_oe(spi_io1_oe), .param_read_active(param_read_active));
  sfp_host_model host_u (.clock(clock), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_io0(spi_io0),
    .spi_io1_o(spi_io1_o), .spi_io1_oe(spi_io1_oe));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (spi_io1_oe === 1'b1) oe_seen = 1'b1;
    if (param_read_active === 1'b1) act_seen = 1'b1;
    cyc++;
    // whole run is about 3500 cycles
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    @(posedge clock);
    #1;
    check("oe", {7'h00, spi_io1_oe}, 8'h00);
    check("active", {7'h00, param_read_active}, 8'h00);
    check("data", {7'h00, spi_io1_o}, 8'h00);
    repeat (5) @(posedge clock);
  endtask

  task automatic t_header();
    logic [7:0] exp [4] = '{8'h10, 8'h30, 8'h00, 8'h00};
    oe_seen = 1'b0;
    act_seen = 1'b0;
    host_u.xfer(8'h5a, 24'h00000b, 4);
    for (int i = 0; i < 4; i++)
      check("header", host_u.rd_q[i], exp[i]);
    check("oe_on_read", {7'h00, oe_seen}, 8'h01);
    check("active_on_read", {7'h00, act_seen}, 8'h01);
    host_u.xfer(8'h5a, 24'h000000, 1);
    check("location_zero", host_u.rd_q[0], SFP_HDR_SIG0);
    $display("test header done");
  endtask

  task automatic t_table();
    logic [7:0] exp [20] = '{8'hff, 8'he5, 8'h20, 8'hf1, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h00, 8'h44,
                             8'heb, 8'h08, 8'h6b, 8'h08, 8'h3b, 8'h80, 8'hbb, 8'hee, 8'hff, 8'hff};
    host_u.xfer(8'h5a, 24'h00002f, 20);
    for (int i = 0; i < 20; i++)
      check("table", host_u.rd_q[i], exp[i]);
    $display("test table done");
  endtask

  task automatic t_bad_op();
    oe_seen = 1'b0;
    act_seen = 1'b0;
    host_u.xfer(8'h03, 24'h000030, 2);
    check("oe_on_bad_op", {7'h00, oe_seen}, 8'h00);
    check("active_on_bad_op", {7'h00, act_seen}, 8'h00);
    $display("test bad opcode done");
  endtask

  task automatic t_rereset();
    do_reset();
    host_u.xfer(8'h5a, 24'h000031, 1);
    check("erase_op", host_u.rd_q[0], 8'h20);
    $display("test second reset done");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    oe_seen = 1'b0;
    act_seen = 1'b0;
    do_reset();
    t_header();
    t_table();
    t_bad_op();
    t_rereset();
    report_and_stop();
  end
endmodule
